/* File: hdl/swr_defines.vh */
// Overview of operation
// [R01] watchdog input stuck past active window asserts reset for full timeout
// [R02] watchdog counter clears on any reset and on each input edge
// [R03] after every reset, long startup window of at least 35 s applies
// [R04] first edge switches to short 1.12 s window; host toggles within it
// [R05] floating watchdog input disables watchdog; never resets from it
// [R06] auxiliary under-threshold flag asserts reset
// [R07] power-fail warning output low while sense flag reports below threshold
// [R08] power-fail warning releases at once, no timeout
// [R09] high reset output asserted on supply, aux, manual or watchdog cause
// [R10] high reset output held for timeout after causes clear
// [R11] recurring cause restarts timeout count from zero
// [R12] reset held while manual reset input is low
// [R13] low reset output mirrors high reset output
// [R14] windows and timeout counted from one timebase, lengths as parameters
// [R15] inputs synchronised before use; edges taken from synchronised input
`ifndef SWR_DEFINES_VH
`define SWR_DEFINES_VH
`define SWR_CLK_HZ        10000000
`define SWR_MS_PER_S      1000
`define SWR_LONG_WIN_MS   35000
`define SWR_SHORT_WIN_MS  1120
`define SWR_TIMEOUT_MS    140
`define SWR_CNT_W         32
`define SWR_SYNC_RST      1'b0
`endif

/* File: hdl/swr_supervisor.v */
`timescale 1ns/1ps
`include "swr_defines.vh"
module swr_supervisor (
   clk_sys,
   rst_b,
   watchdog_kick_in,
   watchdog_float_in,
   manual_reset_n,
   primary_supply_low,
   secondary_supply_low,
   aux_undervoltage_in,
   powerfail_sense_in,
   reset_out_low_primary,
   reset_out_high,
   powerfail_warn_n
);
   parameter [`SWR_CNT_W-1:0] LONG_WIN_CYC  = `SWR_CLK_HZ / `SWR_MS_PER_S * `SWR_LONG_WIN_MS;
   parameter [`SWR_CNT_W-1:0] SHORT_WIN_CYC = `SWR_CLK_HZ / `SWR_MS_PER_S * `SWR_SHORT_WIN_MS;
   parameter [`SWR_CNT_W-1:0] TIMEOUT_CYC   = `SWR_CLK_HZ / `SWR_MS_PER_S * `SWR_TIMEOUT_MS;

   input  wire clk_sys;
   input  wire rst_b;
   input  wire watchdog_kick_in;
   input  wire watchdog_float_in;
   input  wire manual_reset_n;
   input  wire primary_supply_low;
   input  wire secondary_supply_low;
   input  wire aux_undervoltage_in;
   input  wire powerfail_sense_in;
   output reg  reset_out_low_primary;
   output reg  reset_out_high;
   output reg  powerfail_warn_n;

   localparam ST_RUN  = 2'b01;
   localparam ST_HOLD = 2'b10;

   wire kick_s;
   wire float_s;
   wire mr_n_s;
   wire aux_low_s;
   wire pf_low_s;
   wire primary_supply_low_s;
   wire secondary_supply_low_s;
   wire wd_expired;
   wire to_expired;
   wire cause;
   wire wd_fire;
   wire edge_seen;

   reg        kick_d_reg;
   reg        short_mode_reg;
   reg [1:0]  state_reg;
   reg [1:0]  state_next;

   // two-stage synchronisers on every asynchronous flag
   swr_sync #(.RST_VAL(1'b0)) u_sync_kick (.clk_sys(clk_sys), .rst_b(rst_b),
      .d_in(watchdog_kick_in), .q_out(kick_s)); // R15
   swr_sync #(.RST_VAL(1'b1)) u_sync_float (.clk_sys(clk_sys), .rst_b(rst_b),
      .d_in(watchdog_float_in), .q_out(float_s)); // R15
   swr_sync #(.RST_VAL(1'b0)) u_sync_mr (.clk_sys(clk_sys), .rst_b(rst_b),
      .d_in(manual_reset_n), .q_out(mr_n_s)); // R15
   swr_sync #(.RST_VAL(1'b1)) u_sync_aux (.clk_sys(clk_sys), .rst_b(rst_b),
      .d_in(aux_undervoltage_in), .q_out(aux_low_s)); // R15
   swr_sync #(.RST_VAL(1'b1)) u_sync_pf (.clk_sys(clk_sys), .rst_b(rst_b),
      .d_in(powerfail_sense_in), .q_out(pf_low_s)); // R15
   swr_sync #(.RST_VAL(1'b1)) u_sync_v1 (.clk_sys(clk_sys), .rst_b(rst_b),
      .d_in(primary_supply_low), .q_out(primary_supply_low_s)); // R15
   swr_sync #(.RST_VAL(1'b1)) u_sync_v2 (.clk_sys(clk_sys), .rst_b(rst_b),
      .d_in(secondary_supply_low), .q_out(secondary_supply_low_s)); // R15

   assign edge_seen = (kick_s != kick_d_reg); // R15

   // level causes: supplies, aux, manual reset
   assign cause = primary_supply_low_s | secondary_supply_low_s | aux_low_s | !mr_n_s; // R06 R09 R12

   // window chosen by mode; disabled while floating
   assign wd_fire = (state_reg == ST_RUN) && wd_expired && !float_s && !edge_seen; // R01 R05

   swr_timer u_wd_timer (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .clear   ((state_reg != ST_RUN) | edge_seen | float_s), // R02
      .limit   (short_mode_reg ? SHORT_WIN_CYC : LONG_WIN_CYC), // R03 R04 R14
      .expired (wd_expired)
   );

   swr_timer u_to_timer (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .clear   ((state_reg != ST_HOLD) | cause), // R10 R11
      .limit   (TIMEOUT_CYC), // R14
      .expired (to_expired)
   );

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (cause | wd_fire) begin
               state_next = ST_HOLD; // R01 R09
            end
         end
         ST_HOLD: begin
            if (!cause && to_expired) begin
               state_next = ST_RUN; // R10
            end
         end
         default: begin
            state_next = ST_HOLD;
         end
      endcase
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg             <= ST_HOLD;
         kick_d_reg            <= 1'b0;
         short_mode_reg        <= 1'b0;
         reset_out_high        <= 1'b1;
         reset_out_low_primary <= 1'b0;
         powerfail_warn_n      <= 1'b0;
      end else begin
         state_reg  <= state_next;
         kick_d_reg <= kick_s;
         if (state_reg != ST_RUN) begin
            short_mode_reg <= 1'b0; // R03
         end else if (edge_seen && !float_s) begin
            short_mode_reg <= 1'b1; // R04
         end
         reset_out_high        <= (state_next == ST_HOLD); // R09 R10
         reset_out_low_primary <= (state_next != ST_HOLD); // R13
         powerfail_warn_n      <= !pf_low_s; // R07 R08
      end
   end
endmodule // swr_supervisor

/* File: hdl/swr_sync.v */
`timescale 1ns/1ps
module swr_sync (
   clk_sys,
   rst_b,
   d_in,
   q_out
);
   parameter RST_VAL = 1'b0;
   input  wire clk_sys;
   input  wire rst_b;
   input  wire d_in;
   output wire q_out;

   reg meta_reg;
   reg sync_reg;

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign q_out = sync_reg;
endmodule // swr_sync

/* File: hdl/swr_timer.v */
`timescale 1ns/1ps
`include "swr_defines.vh"
module swr_timer (
   clk_sys,
   rst_b,
   clear,
   limit,
   expired
);
   input  wire                   clk_sys;
   input  wire                   rst_b;
   input  wire                   clear;
   input  wire [`SWR_CNT_W-1:0]  limit;
   output wire                   expired;

   reg [`SWR_CNT_W-1:0] count_reg;

   // saturating count; clear restarts from zero
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= {`SWR_CNT_W{1'b0}};
      end else if (clear) begin
         count_reg <= {`SWR_CNT_W{1'b0}};
      end else if (count_reg < limit) begin
         count_reg <= count_reg + {{(`SWR_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign expired = (count_reg >= limit);
endmodule // swr_timer

/* File: tb/swr_checker_properties.sv */
`timescale 1ns/1ps
module swr_checker #(
   parameter TIMEOUT_CYC  = 20,
   parameter LONG_WIN_CYC = 200
) (
   input wire clk_sys,
   input wire rst_b,
   input wire watchdog_kick_in,
   input wire watchdog_float_in,
   input wire manual_reset_n,
   input wire primary_supply_low,
   input wire secondary_supply_low,
   input wire aux_undervoltage_in,
   input wire powerfail_sense_in,
   input wire reset_out_low_primary,
   input wire reset_out_high,
   input wire powerfail_warn_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   reg  [31:0] calm_reg;
   reg  [31:0] idle_reg;
   reg         kick_reg;
   wire        cause = primary_supply_low | secondary_supply_low | aux_undervoltage_in
                       | !manual_reset_n;
   // cycles since last cause, and since last kick edge, reset or floating input
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         calm_reg <= 32'h0;
         idle_reg <= 32'h0;
         kick_reg <= 1'b0;
      end else begin
         calm_reg <= cause ? 32'h0 : calm_reg + 32'h1;
         idle_reg <= (reset_out_high | watchdog_float_in | (kick_reg ^ watchdog_kick_in))
                     ? 32'h0 : idle_reg + 32'h1;
         kick_reg <= watchdog_kick_in;
      end
   end
   outputs_mirror_a: assert property (reset_out_low_primary == !reset_out_high)
      else $error("reset outputs disagree");
   supply_cause_a: assert property (primary_supply_low | secondary_supply_low |-> ##[1:5] reset_out_high)
      else $error("supply low without reset");
   aux_cause_a: assert property (aux_undervoltage_in |-> ##[1:5] reset_out_high)
      else $error("aux low without reset");
   manual_hold_a: assert property (!manual_reset_n |-> ##[1:5] reset_out_high)
      else $error("manual reset ignored");
   warn_low_a: assert property (powerfail_sense_in [*5] |-> !powerfail_warn_n)
      else $error("power-fail warning missing");
   warn_release_a: assert property (!powerfail_sense_in [*5] |-> powerfail_warn_n)
      else $error("power-fail warning stuck");
   hold_time_a: assert property ($fell(reset_out_high) |-> calm_reg >= TIMEOUT_CYC)
      else $error("reset released early");
   wd_bound_a: assert property (idle_reg <= LONG_WIN_CYC + 8)
      else $error("watchdog never fired");
endmodule // swr_checker
bind swr_supervisor swr_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .LONG_WIN_CYC(LONG_WIN_CYC))
   u_swr_checker (.*);

/* File: tb/swr_host.sv */
`timescale 1ns/1ps
module swr_host (
   input  wire       clk_sys,
   input  wire       reset_out_high,
   input  wire       run,
   output reg        kick_reg = 1'b0
);
   reg [7:0] gap_reg = 8'h0;
   // quiet while held in reset, toggles well inside the short window
   always @(negedge clk_sys) begin
      gap_reg <= (reset_out_high | !run) ? 8'h0 : gap_reg + 8'h1;
      if (gap_reg == 8'h14) begin
         kick_reg <= !kick_reg;
         gap_reg <= 8'h0;
      end
   end
endmodule // swr_host

/* File: tb/test_swr_supervisor.sv */
`timescale 1ns/1ps
module test_swr_supervisor;
   localparam [31:0] LW = 32'h0000_00c8;
   localparam [31:0] SW = 32'h0000_0032;
   localparam [31:0] TO = 32'h0000_0014;
   reg       clk_sys = 1'b0, rst_b = 1'b0, flt = 1'b0, mr_n = 1'b1, run = 1'b0, pf = 1'b0;
   reg [2:0] low = 3'h0;
   wire      kick, rst_lo, rst_hi, pf_n;
   integer   n_fail = 0, n_checks = 0, i, j;
   always #50 clk_sys = !clk_sys;
   swr_host u_swr_host (.clk_sys(clk_sys), .reset_out_high(rst_hi), .run(run), .kick_reg(kick));
   swr_supervisor #(.LONG_WIN_CYC(LW), .SHORT_WIN_CYC(SW), .TIMEOUT_CYC(TO)) u_swr_supervisor (
      .clk_sys(clk_sys), .rst_b(rst_b), .watchdog_kick_in(kick), .watchdog_float_in(flt),
      .manual_reset_n(mr_n), .primary_supply_low(low[0]), .secondary_supply_low(low[1]),
      .aux_undervoltage_in(low[2]), .powerfail_sense_in(pf), .reset_out_low_primary(rst_lo),
      .reset_out_high(rst_hi), .powerfail_warn_n(pf_n));
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input logic e, input logic g);
      n_checks = n_checks + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(negedge clk_sys);
   endtask
   task wait_hi(input logic v, input integer lim);
      for (i = 0; i < lim && rst_hi !== v; i = i + 1) tick(1);
      chk("reset_out_high", v, rst_hi);
      if (rst_hi !== v) final_report;
   endtask
   task cause(input integer k, input logic on);
      if (k < 3) low[k] = on;
      else mr_n = !on;
   endtask
   task t_causes;
      for (j = 0; j < 4; j = j + 1) begin
         cause(j, 1'b1);
         wait_hi(1'b1, 6);
         chk("reset_out_low_primary", 1'b0, rst_lo);
         cause(j, 1'b0);
         tick(10);
         cause(j, 1'b1);
         tick(2);
         cause(j, 1'b0);
         tick(TO - 2);
         chk("restarted hold", 1'b1, rst_hi);
         wait_hi(1'b0, 10);
      end
   endtask
   task t_pf;
      pf = 1'b1;
      tick(4);
      chk("powerfail_warn_n", 1'b0, pf_n);
      chk("reset_out_high", 1'b0, rst_hi);
      pf = 1'b0;
      tick(4);
      chk("powerfail_warn_n", 1'b1, pf_n);
   endtask
   task t_wdog;
      run = 1'b1;
      tick(400);
      chk("kicked", 1'b0, rst_hi);
      run = 1'b0;
      tick(25);
      chk("short window", 1'b0, rst_hi);
      wait_hi(1'b1, SW + 10);
      tick(TO - 4);
      chk("wd hold", 1'b1, rst_hi);
      wait_hi(1'b0, 12);
      tick(LW - 10);
      chk("startup window", 1'b0, rst_hi);
      wait_hi(1'b1, 30);
      wait_hi(1'b0, TO + 10);
   endtask
   task t_float;
      flt = 1'b1;
      tick(LW + 50);
      chk("floating", 1'b0, rst_hi);
      flt = 1'b0;
   endtask
   initial begin
      tick(16);
      rst_b = 1'b1;
      wait_hi(1'b0, TO + 10);
      t_causes;
      t_pf;
      t_wdog;
      t_float;
      final_report;
   end
endmodule // test_swr_supervisor
